//--- lock_consts.svh
// opcodes, field positions, reset values and timing counts for the lock
// and soft reset command block; included by the package and the modules
//
// How it works
// - Lock bits govern write protection only while lock scheme select is 1.
// - With lock scheme select 0, protection comes from the range fields alone.
// - Lock bits are volatile and all become 1 at power-up and reset.
// - Lock query is opcode 3Dh then a 24 or 32-bit address.
// - Query answer goes out on falling clock edges, MSB first.
// - Answer LSB is 1 when the addressed unit is locked, else 0.
// - Opcode 7Eh alone, ended by chip select high, sets every lock bit.
// - Opcode 98h alone, ended by chip select high, clears every lock bit.
// - In four-byte address mode the lock query carries a 32-bit address.
// - An accepted software reset aborts internal work, restores power-on state.
// - Software reset clears all volatile status, latch, suspend and read settings.
// - Reset happens only for 66h directly followed by 99h, either mode.
// - Any other command after 66h drops the reset-enabled state.
// - Reset takes about 30us, and all commands are ignored meanwhile.
// - Opcodes 36h and 39h plus address set or clear one lock bit.
`ifndef LOCK_CONSTS_SVH
`define LOCK_CONSTS_SVH

`define OP_READ_LOCK      8'h3D
`define OP_LOCK_ONE       8'h36
`define OP_UNLOCK_ONE     8'h39
`define OP_GLOBAL_LOCK    8'h7E
`define OP_GLOBAL_UNLOCK  8'h98
`define OP_RESET_ENABLE   8'h66
`define OP_RESET          8'h99

`define OPCODE_BITS       6'h08
`define ADDR3_BITS        6'h18
`define ADDR4_BITS        6'h20
`define STEP_SINGLE       6'h01
`define STEP_QUAD         6'h04

`define LOCK_COUNT        542
`define LOCK_IDX_W        10
`define LOCK_RESET_VALUE  1'b1
`define BLOCK_MSB         24
`define BLOCK_LSB         16
`define SECTOR_MSB        15
`define SECTOR_LSB        12
`define LAST_BLOCK        9'h1FF
`define MID_BLOCK_OFFSET  10'h00F
`define TOP_SECTOR_BASE   10'h20E

`define REF_CLK_PERIOD_NS 10
`define RESET_TIME_NS     30000
`define RESET_CYCLES      (`RESET_TIME_NS / `REF_CLK_PERIOD_NS)
`define BUSY_W            12

`endif

//--- lock_pkg.sv
// types shared by the command block and its lock bit array
// assumes lock_consts.svh is on the include path
package lock_pkg;
`include "lock_consts.svh"

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_OPC,
      ST_ADDR,
      ST_CMD,
      ST_OUT,
      ST_SKIP
   } cmd_state_t;

   typedef struct packed {
      logic                    set_all;
      logic                    clear_all;
      logic                    set_one;
      logic                    clear_one;
      logic [`LOCK_IDX_W-1:0]  idx;
   } lock_cmd_t;

endpackage : lock_pkg

//--- lock_bits.sv
// volatile lock bit array, one bit per block or edge sector
// assumes commands arrive as one-cycle pulses on the caller's clock
`timescale 1ns/1ps
`include "lock_consts.svh"
module lock_bits
   import lock_pkg::*;
(
   input  wire logic                   clk,
   input  wire logic                   rstn,
   input  wire logic                   ce,
   input  wire lock_cmd_t              cmd,
   input  wire logic [`LOCK_IDX_W-1:0] rd_idx_a,
   input  wire logic [`LOCK_IDX_W-1:0] rd_idx_b,
   output logic                        rd_a,
   output logic                        rd_b
);
   logic [`LOCK_COUNT-1:0] bits;

   genvar i;
   generate
      for (i = 0; i < `LOCK_COUNT; i++) begin : g_bit
         wire hit = (cmd.idx == `LOCK_IDX_W'(i));
         always_ff @(posedge clk) begin
            if (!rstn)
               bits[i] <= `LOCK_RESET_VALUE;
            else if (ce) begin
               if (cmd.set_all || (cmd.set_one && hit))
                  bits[i] <= 1'b1;
               else if (cmd.clear_all || (cmd.clear_one && hit))
                  bits[i] <= 1'b0;
            end
         end
      end
   endgenerate

   // indices stay below the array size by construction of the decoder
   assign rd_a = bits[rd_idx_a];
   assign rd_b = bits[rd_idx_b];

   all_set_a : assert property (@(posedge clk) disable iff (!rstn)
      ce && cmd.set_all |=> &bits) else $error("global lock missed");
   all_clear_a : assert property (@(posedge clk) disable iff (!rstn)
      ce && cmd.clear_all && !cmd.set_all |=> ~|bits)
      else $error("global unlock missed");
   reset_set_a : assert property (@(posedge clk)
      !rstn |=> &bits) else $error("lock bits not set by reset");

endmodule : lock_bits

//--- flash_lock_cmd.sv
// serial command decoder for lock bits and the two-step soft reset
// assumes CS_N, SCLK and SIO_IN come from the host pins, asynchronous
// to REF_CLK, with SCLK well below a quarter of REF_CLK
`timescale 1ns/1ps
`include "lock_consts.svh"
module flash_lock_cmd
   import lock_pkg::*;
(
   input  wire logic        REF_CLK,
   input  wire logic        RSTN,
   input  wire logic        CE,
   input  wire logic        CS_N,
   input  wire logic        SCLK,
   input  wire logic [3:0]  SIO_IN,
   output logic      [3:0]  SIO_OUT,
   output logic      [3:0]  SIO_OE,
   input  wire logic        QUAD_PERIPHERAL_MODE,
   input  wire logic        ADDR4_MODE,
   input  wire logic        LOCK_SCHEME_SELECT,
   input  wire logic        RANGE_PROTECTED,
   input  wire logic [31:0] CHECK_ADDR,
   output logic             WRITE_PROTECTED,
   output logic             SOFT_RESET,
   output logic             RESET_BUSY
);
   function automatic logic [`LOCK_IDX_W-1:0] lock_index(
      input logic [31:0] a);
      logic [8:0] blk;
      logic [`LOCK_IDX_W-1:0] sec;
      blk = a[`BLOCK_MSB:`BLOCK_LSB];
      sec = {6'h00, a[`SECTOR_MSB:`SECTOR_LSB]};
      if (blk == 9'h000)
         lock_index = sec;
      else if (blk == `LAST_BLOCK)
         lock_index = `TOP_SECTOR_BASE + sec;
      else
         lock_index = {1'b0, blk} + `MID_BLOCK_OFFSET;
   endfunction : lock_index

   // pin synchronisers; stage 1 feeds stage 2 only
   logic [2:0] sclk_s;
   logic [2:0] cs_s;
   logic [3:0] sio_s1;
   logic [3:0] sio_s2;
   always_ff @(posedge REF_CLK) begin
      if (!RSTN) begin
         sclk_s <= 3'h0;
         cs_s   <= 3'h7;
         sio_s1 <= 4'h0;
         sio_s2 <= 4'h0;
      end else if (CE) begin
         sclk_s <= {sclk_s[1:0], SCLK};
         cs_s   <= {cs_s[1:0], CS_N};
         sio_s1 <= SIO_IN;
         sio_s2 <= sio_s1;
      end
   end

   cmd_state_t       state;
   logic [5:0]       cnt;
   logic [7:0]       opc;
   logic [31:0]      addr;
   logic [7:0]       out_sh;
   logic             rst_en;
   logic [`BUSY_W-1:0] busy_cnt;
   lock_cmd_t        lcmd;
   logic             lock_rd;
   logic             lock_chk;

   wire       cs_fall  = cs_s[2] & ~cs_s[1];
   wire       cs_rise  = ~cs_s[2] & cs_s[1];
   wire       sck_rise = ~cs_s[1] & sclk_s[1] & ~sclk_s[2];
   wire       sck_fall = ~cs_s[1] & ~sclk_s[1] & sclk_s[2];
   wire       quad     = QUAD_PERIPHERAL_MODE;
   wire [5:0] step     = quad ? `STEP_QUAD : `STEP_SINGLE;
   wire [5:0] next_cnt = cnt + step;
   wire [5:0] addr_len = ADDR4_MODE ? `ADDR4_BITS : `ADDR3_BITS;
   wire [7:0] next_opc = quad ? {opc[3:0], sio_s2}
                              : {opc[6:0], sio_s2[0]};
   wire [31:0] next_addr = quad ? {addr[27:0], sio_s2}
                                : {addr[30:0], sio_s2[0]};
   wire       opc_has_addr = (next_opc == `OP_READ_LOCK)
                          || (next_opc == `OP_LOCK_ONE)
                          || (next_opc == `OP_UNLOCK_ONE);
   wire       addr_done = (next_cnt == addr_len);
   wire       busy      = (busy_cnt != `BUSY_W'(0));
   // any command whose opcode was fully shifted in counts as a command
   wire       opc_known = (state != ST_IDLE) && (state != ST_OPC);
   wire       end_cmd   = cs_rise && (state == ST_CMD);
   wire       do_reset  = end_cmd && (opc == `OP_RESET) && rst_en;
   wire       do_enable = end_cmd && (opc == `OP_RESET_ENABLE);

   // lock updates happen only when chip select ends a well-formed command
   // one driver for the whole struct keeps strict tools content
   assign lcmd = '{set_all:   (end_cmd && opc == `OP_GLOBAL_LOCK)
                              || do_reset,
                   clear_all: end_cmd && (opc == `OP_GLOBAL_UNLOCK),
                   set_one:   end_cmd && (opc == `OP_LOCK_ONE),
                   clear_one: end_cmd && (opc == `OP_UNLOCK_ONE),
                   idx:       lock_index(addr)};

   lock_bits u_lock_bits (
      .clk      (REF_CLK),
      .rstn     (RSTN),
      .ce       (CE),
      .cmd      (lcmd),
      .rd_idx_a (lock_index(next_addr)),
      .rd_idx_b (lock_index(CHECK_ADDR)),
      .rd_a     (lock_rd),
      .rd_b     (lock_chk)
   );

   // command sequencer
   always_ff @(posedge REF_CLK) begin
      if (!RSTN) begin
         state  <= ST_IDLE;
         cnt    <= 6'h00;
         opc    <= 8'h00;
         addr   <= 32'h0000_0000;
         out_sh <= 8'h00;
      end else if (CE) begin
         if (cs_rise)
            state <= ST_IDLE;
         else if (cs_fall) begin
            state <= busy ? ST_IDLE : ST_OPC;
            cnt   <= 6'h00;
            addr  <= 32'h0000_0000;
         end else if (sck_rise) begin
            case (state)
               ST_OPC: begin
                  opc <= next_opc;
                  cnt <= next_cnt;
                  if (next_cnt == `OPCODE_BITS) begin
                     cnt   <= 6'h00;
                     state <= opc_has_addr ? ST_ADDR : ST_CMD;
                  end
               end
               ST_ADDR: begin
                  addr <= next_addr;
                  cnt  <= next_cnt;
                  if (addr_done) begin
                     if (opc == `OP_READ_LOCK) begin
                        state  <= ST_OUT;
                        out_sh <= {7'h00, lock_rd};
                     end else
                        state <= ST_CMD;
                  end
               end
               // clocks beyond the command make it incomplete
               ST_CMD:  state <= ST_SKIP;
               default: state <= state;
            endcase
         end else if (sck_fall && state == ST_OUT)
            // rotating repeats the same byte for as long as clocks come
            out_sh <= quad ? {out_sh[3:0], out_sh[7:4]}
                           : {out_sh[6:0], out_sh[7]};
      end
   end

   // serial output, changed on falling clock, MSB first
   always_ff @(posedge REF_CLK) begin
      if (!RSTN) begin
         SIO_OUT <= 4'h0;
         SIO_OE  <= 4'h0;
      end else if (CE) begin
         if (cs_rise || state != ST_OUT) begin
            SIO_OE  <= 4'h0;
            SIO_OUT <= 4'h0;
         end else if (sck_fall) begin
            SIO_OE  <= quad ? 4'hF : 4'h2;
            SIO_OUT <= quad ? out_sh[7:4] : {2'h0, out_sh[7], 1'b0};
         end
      end
   end

   // reset enable, reset pulse and recovery interval
   always_ff @(posedge REF_CLK) begin
      if (!RSTN) begin
         rst_en     <= 1'b0;
         busy_cnt   <= `BUSY_W'(0);
         SOFT_RESET <= 1'b0;
      end else if (CE) begin
         SOFT_RESET <= do_reset;
         if (do_reset)
            busy_cnt <= `BUSY_W'(`RESET_CYCLES);
         else if (busy)
            busy_cnt <= busy_cnt - `BUSY_W'(1);
         if (cs_rise && opc_known)
            rst_en <= do_enable;
      end
   end

   // registered so protection never glitches on an address change
   always_ff @(posedge REF_CLK) begin
      if (!RSTN)
         WRITE_PROTECTED <= 1'b1;
      else if (CE)
         WRITE_PROTECTED <= LOCK_SCHEME_SELECT ? lock_chk
                                               : RANGE_PROTECTED;
   end

   assign RESET_BUSY = busy;

   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RSTN);

   scheme_lock_a : assert property (CE && LOCK_SCHEME_SELECT
      |=> WRITE_PROTECTED == $past(lock_chk))
      else $error("lock scheme not applied");
   scheme_range_a : assert property (CE && !LOCK_SCHEME_SELECT
      |=> WRITE_PROTECTED == $past(RANGE_PROTECTED))
      else $error("range scheme not applied");
   status_byte_a : assert property (CE && sck_rise && state == ST_ADDR
      && addr_done && opc == `OP_READ_LOCK
      |=> state == ST_OUT && out_sh == {7'h00, $past(lock_rd)})
      else $error("lock status byte wrong");
   serial_msb_a : assert property (CE && sck_fall && state == ST_OUT
      && !quad && !cs_rise |=> SIO_OE == 4'h2
      && SIO_OUT[1] == $past(out_sh[7]))
      else $error("serial bit not msb first");
   addr_long_a : assert property (CE && ADDR4_MODE && sck_rise
      && state == ST_ADDR && next_cnt == `ADDR3_BITS && !cs_rise
      && !cs_fall |=> state == ST_ADDR)
      else $error("four byte address cut short");
   enable_drop_a : assert property (CE && cs_rise && opc_known
      && !do_enable |=> !rst_en)
      else $error("reset enable survived other command");
   reset_pair_a : assert property (SOFT_RESET
      |-> $past(rst_en) && $past(opc) == `OP_RESET)
      else $error("reset without enable");
   recovery_a : assert property (CE && do_reset
      |=> (busy_cnt == `BUSY_W'(`RESET_CYCLES)) ##0 RESET_BUSY[*8])
      else $error("recovery interval not started");
   busy_ignore_a : assert property (CE && busy && cs_fall
      |=> state == ST_IDLE)
      else $error("command taken while busy");

   query_c : cover property (sck_fall && state == ST_OUT);
   global_lock_c : cover property (lcmd.set_all && !do_reset);
   soft_reset_c : cover property (SOFT_RESET);
   dropped_enable_c : cover property (cs_rise && opc_known && rst_en
      && !do_reset && !do_enable);

endmodule : flash_lock_cmd

//--- flash_host_model.sv
// host controller model: frames opcodes, addresses and read-back on pins
// assumes the bench calls power_up once, then xfer for every command
`timescale 1ns/1ps
module flash_host_model #(
   parameter int HALF       = 4,
   parameter int PUW_CYCLES = 50
) (
   input  wire logic       ref_clk,
   input  wire logic [3:0] sio_out,
   output logic            cs_n,
   output logic            sclk,
   output logic [3:0]      sio_in
);
   initial begin
      cs_n   = 1'b1;
      sclk   = 1'b0;
      sio_in = 4'h0;
   end

   task automatic idle(input int n);
      repeat (n) @(negedge ref_clk);
   endtask : idle

   // scaled down so the run stays short
   task automatic power_up;
      idle(PUW_CYCLES);
   endtask : power_up

   // one framed command; sclk stands low between frames
   task automatic xfer(input logic [7:0] op, input int abits,
                       input logic [31:0] addr, input int rbits,
                       input logic quad, output logic [15:0] rd);
      logic [39:0] sh;
      int          step;
      int          n;
      step = quad ? 4 : 1;
      sh   = {op, addr << (32 - abits)};
      n    = 8 + abits;
      rd   = 16'h0000;
      @(negedge ref_clk);
      cs_n = 1'b0;
      for (int i = 0; i < n + rbits; i += step) begin
         if (i < n) begin
            sio_in = quad ? sh[39:36] : {3'h0, sh[39]};
            sh = sh << step;
         end else begin
            sio_in = ~sio_in; // released: never a stale level
         end
         idle(HALF);
         sclk = 1'b1;
         idle(HALF);
         if (i >= n)
            rd = quad ? {rd[11:0], sio_out} : {rd[14:0], sio_out[1]};
         sclk = 1'b0;
      end
      idle(HALF);
      cs_n   = 1'b1;
      sio_in = ~sio_in;
      idle(2 * HALF);
   endtask : xfer
endmodule : flash_host_model

//--- tb_flash_lock_cmd.sv
// self-checking bench for the lock and soft reset command block
// assumes lock_pkg is compiled first and the host model beside it
`timescale 1ns/1ps
`include "lock_consts.svh"
module tb_flash_lock_cmd;
   import lock_pkg::*;
   logic        REF_CLK, RSTN, CE, CS_N, SCLK, QPM, A4, LSS, RP;
   logic        WRITE_PROTECTED, SOFT_RESET, RESET_BUSY;
   logic [3:0]  SIO_IN, SIO_OUT, SIO_OE, oe_seen;
   logic [31:0] CHECK_ADDR, a, b;
   logic [15:0] rd;
   int          error_cnt, samples_checked, resets, busy_len;

   flash_lock_cmd dut_u (.REF_CLK(REF_CLK), .RSTN(RSTN), .CE(CE),
      .CS_N(CS_N), .SCLK(SCLK), .SIO_IN(SIO_IN), .SIO_OUT(SIO_OUT),
      .SIO_OE(SIO_OE), .QUAD_PERIPHERAL_MODE(QPM), .ADDR4_MODE(A4),
      .LOCK_SCHEME_SELECT(LSS), .RANGE_PROTECTED(RP),
      .CHECK_ADDR(CHECK_ADDR), .WRITE_PROTECTED(WRITE_PROTECTED),
      .SOFT_RESET(SOFT_RESET), .RESET_BUSY(RESET_BUSY));
   flash_host_model host_u (.ref_clk(REF_CLK), .sio_out(SIO_OUT),
      .cs_n(CS_N), .sclk(SCLK), .sio_in(SIO_IN));

   initial begin
      REF_CLK = 1'b0;
      forever #5 REF_CLK = ~REF_CLK;
   end
   always @(posedge REF_CLK) begin
      if (SOFT_RESET === 1'b1) resets++;
      if (RESET_BUSY === 1'b1) busy_len++;
      if (SIO_OE !== 4'h0) oe_seen <= SIO_OE;
   end

   function automatic logic [7:0] exp_byte(input logic lock);
      return {7'h00, lock};
   endfunction : exp_byte
   function automatic logic exp_wp(input logic s, r, lock);
      return s ? lock : r;
   endfunction : exp_wp

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : give_verdict
   task automatic chk1(input string nm, input logic e, g);
      samples_checked++;
      if (g !== e) begin
         error_cnt++;
         $display("BAD %s exp %b got %b", nm, e, g);
      end
   endtask : chk1
   task automatic chk8(input string nm, input logic [7:0] e, g);
      samples_checked++;
      if (g !== e) begin
         error_cnt++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask : chk8
   task automatic chkn(input string nm, input int e, g);
      samples_checked++;
      if (g != e) begin
         error_cnt++;
         $display("BAD %s exp %0d got %0d", nm, e, g);
      end
   endtask : chkn
   // settle two edges past the registered output
   task automatic wp_at(input logic [31:0] ad);
      CHECK_ADDR = ad;
      repeat (3) @(negedge REF_CLK);
   endtask : wp_at
   task automatic cmd(input logic [7:0] op, input int ab = 0,
                      input logic [31:0] ad = 0, input int rb = 0);
      host_u.xfer(op, ab, ad, rb, QPM, rd);
   endtask : cmd

   initial begin
      {RSTN, QPM, A4, RP} = 4'h0;
      {CE, LSS} = 2'h3;
      CHECK_ADDR = 32'h0000_0000;
      void'($urandom(22));
      repeat (5) @(negedge REF_CLK);
      RSTN = 1'b1;
      host_u.power_up();
      for (int i = 0; i < 4; i++) begin
         a = $urandom;
         LSS = 1'b1;
         wp_at(a);
         chk1("wp_reset", exp_wp(1'b1, 1'b0, 1'b1), WRITE_PROTECTED);
         LSS = 1'b0;
         RP  = 1'($urandom);
         wp_at(a);
         chk1("wp_range", exp_wp(1'b0, RP, 1'b1), WRITE_PROTECTED);
      end
      $display("test reset state done");
      a = $urandom & 32'h00FF_F000;
      b = a ^ 32'h0002_0000;
      RP = 1'b1;
      cmd(`OP_GLOBAL_UNLOCK);
      wp_at(a);
      chk1("wp_scheme0", exp_wp(1'b0, 1'b1, 1'b0), WRITE_PROTECTED);
      LSS = 1'b1;
      wp_at(a);
      chk1("wp_unlock", exp_wp(1'b1, 1'b1, 1'b0), WRITE_PROTECTED);
      cmd(`OP_READ_LOCK, 24, a, 16);
      chk8("query0", exp_byte(1'b0), rd[15:8]);
      cmd(`OP_LOCK_ONE, 24, a);
      cmd(`OP_READ_LOCK, 24, a, 16);
      chk8("query1", exp_byte(1'b1), rd[15:8]);
      chk8("repeat1", exp_byte(1'b1), rd[7:0]);
      chk8("oe_single", 8'h02, {4'h0, oe_seen});
      chk8("oe_idle", 8'h00, {4'h0, SIO_OE});
      wp_at(b);
      chk1("wp_other", 1'b0, WRITE_PROTECTED);
      $display("test single lane done");
      {QPM, A4} = 2'h3;
      a = $urandom & 32'h01FF_F000;
      cmd(`OP_GLOBAL_LOCK);
      wp_at(b);
      chk1("wp_glock", 1'b1, WRITE_PROTECTED);
      cmd(`OP_UNLOCK_ONE, 32, a);
      cmd(`OP_READ_LOCK, 32, a, 16);
      chk8("qquery", exp_byte(1'b0), rd[15:8]);
      chk8("qrepeat", exp_byte(1'b0), rd[7:0]);
      chk8("oe_quad", 8'h0F, {4'h0, oe_seen});
      wp_at(a);
      chk1("wp_qunlock", 1'b0, WRITE_PROTECTED);
      $display("test quad lane done");
      {QPM, A4} = 2'h0;
      resets = 0;
      cmd(`OP_RESET_ENABLE);
      cmd(`OP_READ_LOCK, 24, a, 8);
      cmd(`OP_RESET);
      chkn("no_reset", 0, resets);
      $display("test broken pair done");
      QPM = 1'b1;
      chk1("busy_before", 1'b0, RESET_BUSY);
      cmd(`OP_RESET_ENABLE);
      busy_len = 0;
      cmd(`OP_RESET);
      chkn("reset_cnt", 1, resets);
      cmd(`OP_GLOBAL_UNLOCK);
      for (int i = 0; i < 4000 && RESET_BUSY !== 1'b0; i++)
         @(negedge REF_CLK);
      if (RESET_BUSY !== 1'b0) begin
         error_cnt++;
         give_verdict();
      end
      chkn("busy_len", `RESET_CYCLES, busy_len);
      wp_at(a);
      chk1("wp_after", 1'b1, WRITE_PROTECTED);
      cmd(`OP_GLOBAL_UNLOCK);
      wp_at(a);
      chk1("wp_alive", 1'b0, WRITE_PROTECTED);
      $display("test soft reset done");
      give_verdict();
   end

   initial begin
      #900_000;
      error_cnt++;
      give_verdict();
   end
endmodule : tb_flash_lock_cmd
